// ===== design/gpc_top.sv
// Chosen here: the AXI4-Lite interface to the registers.
module gpc_top
   import gpc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic main_por,
   input wire logic hard_rst,
   input wire logic [GPC_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [GPC_DW-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [GPC_AW-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [GPC_DW-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   input wire logic power_event,
   input wire logic [GPC_NPIN-1:0] pad_in,
   output logic [GPC_NPIN-1:0] pad_out,
   output logic [GPC_NPIN-1:0] pad_oe,
   output logic floppy_parallel_select,
   output logic disable_reg_guard,
   output logic [2:0] isa_irq,
   output logic irq
);

   typedef struct packed {
      logic [GPC_NPIN-1:0][7:0] cfg;
      logic [GPC_NPIN-1:0] dout;
      logic [GPC_NEV-1:0] status;
      logic [GPC_NEV-1:0] mask;
      logic prev_43;
      logic aw_got;
      logic [GPC_AW-1:0] aw_addr;
      logic w_got;
      logic [GPC_DW-1:0] w_data;
      logic [3:0] w_strb;
      gpc_wr_e wst;
      logic [1:0] bresp;
      gpc_rd_e rst;
      logic [GPC_DW-1:0] rdata;
      logic [1:0] rresp;
   } gpc_state_s;

   gpc_state_s state_q;
   gpc_state_s state_d;

   logic [GPC_NPIN-1:0] eff_dir;
   logic [GPC_NPIN-1:0] eff_pol;
   logic [GPC_NPIN-1:0] eff_od;
   logic [GPC_NPIN-1:0] out_val;
   logic [GPC_NPIN-1:0] in_val;
   logic [1:0] alt_43;
   logic [GPC_NEV-1:0] events;
   logic aw_take;
   logic w_take;
   logic ar_take;

   // Address decode shared by the read and the write path
   function automatic logic [3:0] gpc_sel(input logic [GPC_AW-1:0] addr);
      logic [3:0] sel;
      sel = GPC_SEL_NONE;
      if (addr[1:0] == 2'h0) begin
         case (addr[GPC_AW-1:2])
            GPC_IDX_PIN_4_2: sel = 4'h0;
            GPC_IDX_PIN_4_3: sel = 4'h1;
            GPC_IDX_PIN_5_0: sel = 4'h2;
            GPC_IDX_PIN_5_1: sel = 4'h3;
            GPC_IDX_PIN_5_2: sel = 4'h4;
            GPC_IDX_DATA: sel = GPC_SEL_DATA;
            GPC_IDX_STATUS: sel = GPC_SEL_STATUS;
            GPC_IDX_MASK: sel = GPC_SEL_MASK;
            default: sel = GPC_SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   assign alt_43 = state_q.cfg[GPC_P43][GPC_B_ALT_HI:GPC_B_ALT];

   // Per-pin effective settings; guard mode and the power event override the GPIO path
   for (genvar k = 0; k < GPC_NPIN; k++) begin : g_pin
      if (k == GPC_P43) begin : g_guard
         // Guard mode pins the pad to a plain input whatever bits 1:0 say
         assign eff_dir[k] = (alt_43 == GPC_ALT_GUARD) | state_q.cfg[k][GPC_B_DIR];
         assign eff_pol[k] = (alt_43 != GPC_ALT_GUARD) & state_q.cfg[k][GPC_B_POL];
      end else begin : g_plain
         assign eff_dir[k] = state_q.cfg[k][GPC_B_DIR];
         assign eff_pol[k] = state_q.cfg[k][GPC_B_POL];
      end
      if (k == GPC_P42) begin : g_pme
         // Event is active high inside, so its inverse gives a low-true pad
         assign out_val[k] = state_q.cfg[k][GPC_B_ALT] ? ~power_event : state_q.dout[k];
      end else begin : g_gpio
         assign out_val[k] = state_q.dout[k];
      end
      assign eff_od[k] = state_q.cfg[k][GPC_B_OTYPE];
      gpc_pin u_pin (
         .out_val(out_val[k]),
         .pol(eff_pol[k]),
         .dir_in(eff_dir[k]),
         .open_drain(eff_od[k]),
         .pad_in(pad_in[k]),
         .pad_out(pad_out[k]),
         .pad_oe(pad_oe[k]),
         .in_val(in_val[k])
      );
   end

   // ISA request routing on the three port-5 pins; reserved codes give nothing
   for (genvar j = 0; j < 3; j++) begin : g_isa
      assign isa_irq[j] = (state_q.cfg[j + GPC_P50][GPC_B_ALT_HI:GPC_B_ALT] == GPC_ALT_SEL)
                          & in_val[j + GPC_P50];
   end

   // Pin 4.3 side functions
   assign floppy_parallel_select = (alt_43 == GPC_ALT_SEL) & in_val[GPC_P43];
   assign disable_reg_guard = (alt_43 == GPC_ALT_GUARD) & pad_in[GPC_P43];

   // Either-edge detection; the mask bit is the per-source enable
   assign events[GPC_EV_EDGE] = (alt_43 == GPC_ALT_EDGE)
                                & (in_val[GPC_P43] != state_q.prev_43);
   assign events[GPC_EV_SEL] = (alt_43 == GPC_ALT_SEL)
                               & (in_val[GPC_P43] != state_q.prev_43);
   assign irq = |(state_q.status & state_q.mask);

   // Bus handshakes are combinational from the state
   assign awready = (state_q.wst == GPC_WS_IDLE) & ~state_q.aw_got;
   assign wready = (state_q.wst == GPC_WS_IDLE) & ~state_q.w_got;
   assign arready = (state_q.rst == GPC_RS_IDLE);
   assign aw_take = awvalid & awready;
   assign w_take = wvalid & wready;
   assign ar_take = arvalid & arready;
   assign bvalid = (state_q.wst == GPC_WS_RESP);
   assign bresp = state_q.bresp;
   assign rvalid = (state_q.rst == GPC_RS_DATA);
   assign rdata = state_q.rdata;
   assign rresp = state_q.rresp;

   // Next-state logic: bus slave, register file, events
   always_comb begin
      logic [GPC_AW-1:0] waddr;
      logic [GPC_DW-1:0] wd;
      logic [3:0] ws;
      logic [3:0] rs;
      logic [7:0] wm;
      logic stat_clr;
      waddr = aw_take ? awaddr : state_q.aw_addr;
      wd = w_take ? wdata : state_q.w_data;
      ws = gpc_sel(waddr);
      rs = gpc_sel(araddr);
      wm = 8'h00;
      stat_clr = 1'b0;
      state_d = state_q;
      state_d.prev_43 = in_val[GPC_P43];
      if (aw_take) begin
         state_d.aw_got = 1'b1;
         state_d.aw_addr = awaddr;
      end
      if (w_take) begin
         state_d.w_got = 1'b1;
         state_d.w_data = wdata;
         state_d.w_strb = wstrb;
      end
      // Write commits once both address and data are in, in either order
      if ((state_q.aw_got | aw_take) & (state_q.w_got | w_take)) begin
         state_d.aw_got = 1'b0;
         state_d.w_got = 1'b0;
         state_d.wst = GPC_WS_RESP;
         state_d.bresp = (ws == GPC_SEL_NONE) ? GPC_RESP_SLVERR : GPC_RESP_OKAY;
         // Only lane 0 carries data; a write without it changes nothing
         if ((w_take ? wstrb[0] : state_q.w_strb[0])) begin
            for (int k = 0; k < GPC_NPIN; k++) begin
               wm = (k == GPC_P42) ? GPC_WMASK_1ALT : GPC_WMASK_2ALT;
               // A locked guard field keeps its code until a reset
               if (k == GPC_P43 && alt_43 == GPC_ALT_GUARD) begin
                  wm[GPC_B_ALT_HI:GPC_B_ALT] = 2'h0;
               end
               if (ws == k[3:0]) begin
                  state_d.cfg[k] = (state_q.cfg[k] & ~wm) | (wd[7:0] & wm);
               end
            end
            if (ws == GPC_SEL_DATA) begin
               state_d.dout = wd[GPC_NPIN-1:0];
            end
            if (ws == GPC_SEL_MASK) begin
               state_d.mask = wd[GPC_NEV-1:0];
            end
         end
      end
      if (bvalid & bready) begin
         state_d.wst = GPC_WS_IDLE;
      end
      // Read answers one cycle after the address is taken
      if (ar_take) begin
         state_d.rst = GPC_RS_DATA;
         state_d.rresp = GPC_RESP_OKAY;
         state_d.rdata = '0;
         if (rs < 4'h5) begin
            state_d.rdata[7:0] = state_q.cfg[rs[2:0]];
         end else if (rs == GPC_SEL_DATA) begin
            state_d.rdata[GPC_NPIN-1:0] = in_val;
         end else if (rs == GPC_SEL_STATUS) begin
            state_d.rdata[GPC_NEV-1:0] = state_q.status;
            stat_clr = 1'b1;
         end else if (rs == GPC_SEL_MASK) begin
            state_d.rdata[GPC_NEV-1:0] = state_q.mask;
         end else begin
            state_d.rresp = GPC_RESP_SLVERR;
         end
      end
      if (rvalid & rready) begin
         state_d.rst = GPC_RS_IDLE;
      end
      // Read clears the sticky bits, but an event in the same cycle survives
      state_d.status = (stat_clr ? '0 : state_q.status) | events;
      // These resets act on the pin 4.3 field only and beat any write
      if (main_por | hard_rst) begin
         state_d.cfg[GPC_P43][GPC_B_ALT_HI:GPC_B_ALT] = GPC_ALT_GPIO;
      end
   end

   // The bus reset stands for the standby power-on reset and resets it all, each pin config to 01h
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_q <= '0;
         for (int k = 0; k < GPC_NPIN; k++) begin
            state_q.cfg[k] <= GPC_CFG_RST;
         end
         state_q.wst <= GPC_WS_IDLE;
         state_q.rst <= GPC_RS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_43_edge_mode;
      (alt_43 == GPC_ALT_EDGE) && (in_val[GPC_P43] != state_q.prev_43);
   endsequence

   sequence s_43_sel_toggle;
      (alt_43 == GPC_ALT_SEL) && (in_val[GPC_P43] != state_q.prev_43);
   endsequence

   a_input_no_drive: assert property (
      state_q.cfg[GPC_P50][GPC_B_DIR] |-> !pad_oe[GPC_P50])
      else $error("input pin is driven");
   a_isa_polarity: assert property (
      (state_q.cfg[3][GPC_B_ALT_HI:GPC_B_ALT] == GPC_ALT_SEL)
      |-> (isa_irq[1] == (pad_in[3] ^ state_q.cfg[3][GPC_B_POL])))
      else $error("ISA route ignores polarity");
   a_od_low_only: assert property (
      (state_q.cfg[GPC_P50 + 1][GPC_B_OTYPE] && pad_oe[GPC_P50 + 1]) |-> !pad_out[GPC_P50 + 1])
      else $error("open drain drives high");
   a_pme_active_low: assert property (
      (state_q.cfg[GPC_P42][2:0] == 3'h4 && !state_q.cfg[GPC_P42][GPC_B_OTYPE])
      |-> (pad_oe[GPC_P42] && pad_out[GPC_P42] == !power_event))
      else $error("power event not active low");
   a_pme_open_drain: assert property (
      (state_q.cfg[GPC_P42] == 8'h84) |-> (pad_oe[GPC_P42] == power_event))
      else $error("power event open drain wrong");
   a_edge_sets_status: assert property (
      s_43_edge_mode |=> state_q.status[GPC_EV_EDGE])
      else $error("edge did not set status");
   a_sel_edge_status: assert property (
      s_43_sel_toggle |=> state_q.status[GPC_EV_SEL])
      else $error("select toggle did not set status");
   a_sel_follows_pin: assert property (
      (alt_43 == GPC_ALT_SEL)
      |-> (floppy_parallel_select == (pad_in[GPC_P43] ^ state_q.cfg[GPC_P43][GPC_B_POL])))
      else $error("select sense wrong");
   a_guard_forced_in: assert property (
      (alt_43 == GPC_ALT_GUARD) |-> (!pad_oe[GPC_P43] && in_val[GPC_P43] == pad_in[GPC_P43]))
      else $error("guard pin not a plain input");
   a_guard_locked: assert property (
      (alt_43 == GPC_ALT_GUARD && !main_por && !hard_rst) |=> (alt_43 == GPC_ALT_GUARD))
      else $error("locked field changed");
   a_reset_clears_alt: assert property (
      (main_por || hard_rst) |=> (alt_43 == GPC_ALT_GPIO))
      else $error("field not cleared by reset");
   a_guard_readonly: assert property (
      (alt_43 == GPC_ALT_GUARD) |-> (disable_reg_guard == pad_in[GPC_P43]))
      else $error("guard output wrong");
   a_reserved_zero: assert property (
      (state_q.cfg[GPC_P42][6:3] == 4'h0) && (state_q.cfg[GPC_P43][6:4] == 3'h0)
      && (state_q.cfg[4][6:4] == 3'h0))
      else $error("reserved bits set");
   a_read_answers: assert property (
      ar_take |=> rvalid)
      else $error("read not answered");

endmodule

// ===== design/gpc_pkg.sv
package gpc_pkg;

   // Bus geometry
   localparam int GPC_AW = 10;
   localparam int GPC_DW = 32;
   localparam int GPC_NPIN = 5;
   localparam int GPC_NEV = 2;

   // Register indices; the byte address is four times the index
   localparam logic [7:0] GPC_IDX_PIN_4_2 = 8'h3d;
   localparam logic [7:0] GPC_IDX_PIN_4_3 = 8'h3e;
   localparam logic [7:0] GPC_IDX_PIN_5_0 = 8'h3f;
   localparam logic [7:0] GPC_IDX_PIN_5_1 = 8'h40;
   localparam logic [7:0] GPC_IDX_PIN_5_2 = 8'h41;
   localparam logic [7:0] GPC_IDX_DATA = 8'h50;
   localparam logic [7:0] GPC_IDX_STATUS = 8'h51;
   localparam logic [7:0] GPC_IDX_MASK = 8'h52;

   // Pin positions inside the group
   localparam int GPC_P42 = 0;
   localparam int GPC_P43 = 1;
   localparam int GPC_P50 = 2;

   // Register select codes from the address decoder
   localparam logic [3:0] GPC_SEL_DATA = 4'h5;
   localparam logic [3:0] GPC_SEL_STATUS = 4'h6;
   localparam logic [3:0] GPC_SEL_MASK = 4'h7;
   localparam logic [3:0] GPC_SEL_NONE = 4'hf;

   // Configuration field positions
   localparam int GPC_B_DIR = 0;
   localparam int GPC_B_POL = 1;
   localparam int GPC_B_ALT = 2;
   localparam int GPC_B_ALT_HI = 3;
   localparam int GPC_B_OTYPE = 7;

   // Reset values and writable-bit masks
   localparam logic [7:0] GPC_CFG_RST = 8'h01;
   localparam logic [7:0] GPC_WMASK_1ALT = 8'h87;
   localparam logic [7:0] GPC_WMASK_2ALT = 8'h8f;

   // Alternate function codes of the two-bit field
   localparam logic [1:0] GPC_ALT_GPIO = 2'h0;
   localparam logic [1:0] GPC_ALT_GUARD = 2'h1;
   localparam logic [1:0] GPC_ALT_SEL = 2'h2;
   localparam logic [1:0] GPC_ALT_EDGE = 2'h3;

   // Event bits of the status and mask registers
   localparam int GPC_EV_EDGE = 0;
   localparam int GPC_EV_SEL = 1;

   // Bus responses
   localparam logic [1:0] GPC_RESP_OKAY = 2'h0;
   localparam logic [1:0] GPC_RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      GPC_WS_IDLE = 2'h0,
      GPC_WS_RESP = 2'h1
   } gpc_wr_e;

   typedef enum logic [1:0] {
      GPC_RS_IDLE = 2'h0,
      GPC_RS_DATA = 2'h1
   } gpc_rd_e;

endpackage

// ===== design/gpc_pin.sv
// One pad: polarity, direction and driver type between pin and logic
module gpc_pin
   import gpc_pkg::*;
(
   input wire logic out_val,
   input wire logic pol,
   input wire logic dir_in,
   input wire logic open_drain,
   input wire logic pad_in,
   output logic pad_out,
   output logic pad_oe,
   output logic in_val
);

   logic drive;

   // Logic level after the polarity stage
   assign drive = out_val ^ pol;
   assign in_val = pad_in ^ pol;

   // Open drain only ever pulls low; an input never drives
   always_comb begin
      pad_out = drive;
      pad_oe = 1'b0;
      if (!dir_in) begin
         if (open_drain) begin
            pad_out = 1'b0;
            pad_oe = ~drive;
         end else begin
            pad_oe = 1'b1;
         end
      end
   end

endmodule

// ===== verification/gpc_board.sv
// Board side of the five pads: a pull-up on every line plus an optional external driver
module gpc_board
   import gpc_pkg::*;
(
   input wire logic [GPC_NPIN-1:0] pad_out,
   input wire logic [GPC_NPIN-1:0] pad_oe,
   input wire logic [GPC_NPIN-1:0] ext_en,
   input wire logic [GPC_NPIN-1:0] ext_val,
   output logic [GPC_NPIN-1:0] pad_in
);
   timeunit 1ns;
   timeprecision 1ps;

   // The device wins over the board driver; contention is not modelled, so the bench
   // releases its driver on pads that the device drives
   always_comb begin
      for (int i = 0; i < GPC_NPIN; i++) begin
         if (pad_oe[i]) begin
            pad_in[i] = pad_out[i];
         end else if (ext_en[i]) begin
            pad_in[i] = ext_val[i];
         end else begin
            pad_in[i] = 1'b1; // Pull-up, so a released open-drain line reads high
         end
      end
   end
endmodule

// ===== verification/gpio_pin_config_group_tb.sv
module gpio_pin_config_group_tb
   import gpc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic main_por = 1'b0;
   logic hard_rst = 1'b0;
   logic power_event = 1'b0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [GPC_AW-1:0] awaddr = '0;
   logic [GPC_AW-1:0] araddr = '0;
   logic [GPC_DW-1:0] wdata = '0;
   logic [3:0] wstrb = 4'hf;
   logic [GPC_NPIN-1:0] ext_en = 5'h1f;
   logic [GPC_NPIN-1:0] ext_val = 5'h00;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic floppy_parallel_select, disable_reg_guard;
   logic [1:0] bresp, rresp;
   logic [GPC_DW-1:0] rdata;
   logic [GPC_NPIN-1:0] pad_in, pad_out, pad_oe;
   logic [2:0] isa_irq;
   int mismatches = 0;
   int n_compared = 0;

   // 125 MHz
   always #4 aclk = ~aclk;

   gpc_top DUT (.aclk(aclk), .aresetn(aresetn), .main_por(main_por), .hard_rst(hard_rst),
      .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
      .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .power_event(power_event), .pad_in(pad_in),
      .pad_out(pad_out), .pad_oe(pad_oe), .floppy_parallel_select(floppy_parallel_select),
      .disable_reg_guard(disable_reg_guard), .isa_irq(isa_irq), .irq(irq));

   gpc_board board (.pad_out(pad_out), .pad_oe(pad_oe), .ext_en(ext_en), .ext_val(ext_val),
      .pad_in(pad_in));

   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // One bus transfer; handshakes are judged at the falling edge, where nothing moves
   task automatic axi(input bit is_wr, input logic [7:0] idx, input logic [31:0] d,
                      output logic [31:0] q, output logic [1:0] r);
      bit a_t, w_t, ar_t, done;
      int n;
      done = 1'b0;
      n = 0;
      @(posedge aclk);
      if (is_wr) begin
         awaddr <= {idx, 2'b00};
         wdata <= d;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         bready <= 1'b1;
      end else begin
         araddr <= {idx, 2'b00};
         arvalid <= 1'b1;
         rready <= 1'b1;
      end
      while (!done) begin
         @(negedge aclk);
         a_t = awvalid && awready;
         w_t = wvalid && wready;
         ar_t = arvalid && arready;
         done = is_wr ? (bvalid === 1'b1) : (rvalid === 1'b1);
         q = rdata;
         r = is_wr ? bresp : rresp;
         @(posedge aclk);
         if (a_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
         if (ar_t) arvalid <= 1'b0;
         n++;
         if (n > 50) begin
            mismatches++;
            end_of_test();
         end
      end
      bready <= 1'b0;
      rready <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      logic [31:0] q;
      logic [1:0] r;
      axi(1'b1, idx, d, q, r);
   endtask

   task automatic rd(input logic [7:0] idx, output logic [31:0] q);
      logic [1:0] r;
      axi(1'b0, idx, 32'h0, q, r);
   endtask

   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", s, e, g);
      end
   endtask

   task automatic rdc(input string s, input logic [7:0] idx, input logic [31:0] e);
      logic [31:0] q;
      rd(idx, q);
      chk(s, e, q);
   endtask

   // Pad outputs are combinational from registers; two edges let any update land
   task automatic look;
      repeat (2) @(posedge aclk);
      @(negedge aclk);
   endtask

   task automatic drive(input logic [4:0] en, input logic [4:0] val);
      @(posedge aclk);
      ext_en <= en;
      ext_val <= val;
   endtask

   task automatic pulse(input bit hard);
      @(posedge aclk);
      if (hard) hard_rst <= 1'b1;
      else main_por <= 1'b1;
      @(posedge aclk);
      hard_rst <= 1'b0;
      main_por <= 1'b0;
   endtask

   task automatic do_reset;
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
   endtask

   // Reset values, and an unmapped place that must be refused both ways
   task automatic t_reset;
      logic [31:0] q;
      logic [1:0] r;
      for (int i = 0; i < GPC_NPIN; i++) begin
         rdc("cfg reset", 8'(GPC_IDX_PIN_4_2 + i), 32'h01);
      end
      rdc("status reset", GPC_IDX_STATUS, 32'h0);
      rdc("mask reset", GPC_IDX_MASK, 32'h0);
      chk("oe reset", 32'h0, pad_oe);
      axi(1'b0, 8'hff, 32'h0, q, r);
      chk("rd unmapped", GPC_RESP_SLVERR, r);
      axi(1'b1, 8'hff, 32'h5a, q, r);
      chk("wr unmapped", GPC_RESP_SLVERR, r);
      // A write without byte lane 0 is answered but changes nothing
      wstrb <= 4'he;
      axi(1'b1, GPC_IDX_PIN_4_2, 32'h80, q, r);
      chk("wr no lane", GPC_RESP_OKAY, r);
      wstrb <= 4'hf;
      rdc("wr no lane kept", GPC_IDX_PIN_4_2, 32'h01);
   endtask

   // All ones written; only the documented bits may stick
   task automatic t_reserved;
      for (int i = 0; i < GPC_NPIN; i++) begin
         wr(8'(GPC_IDX_PIN_4_2 + i), 32'hffff_ffff);
         rdc("cfg bits", 8'(GPC_IDX_PIN_4_2 + i), (i == 0) ? 32'h87 : 32'h8f);
         wr(8'(GPC_IDX_PIN_4_2 + i), 32'h01);
      end
   endtask

   // Direction, polarity and driver type on pin 5.1 (pad 3)
   task automatic t_out;
      logic [31:0] q;
      drive(5'h17, 5'h00);
      wr(GPC_IDX_PIN_5_1, 32'h00);
      wr(GPC_IDX_DATA, 32'h08);
      look();
      chk("push pull oe", 1'h1, pad_oe[3]);
      chk("push pull out", 1'h1, pad_out[3]);
      wr(GPC_IDX_PIN_5_1, 32'h02);
      look();
      chk("inverted out", 1'h0, pad_out[3]);
      wr(GPC_IDX_PIN_5_1, 32'h80);
      look();
      chk("open drain high oe", 1'h0, pad_oe[3]);
      wr(GPC_IDX_DATA, 32'h00);
      look();
      chk("open drain low oe", 1'h1, pad_oe[3]);
      chk("open drain low out", 1'h0, pad_out[3]);
      wr(GPC_IDX_PIN_5_1, 32'h01);
      drive(5'h1f, 5'h08);
      look();
      chk("input oe", 1'h0, pad_oe[3]);
      rd(GPC_IDX_DATA, q);
      chk("input level", 1'h1, q[3]);
      wr(GPC_IDX_PIN_5_1, 32'h03);
      rd(GPC_IDX_DATA, q);
      chk("inverted input", 1'h0, q[3]);
   endtask

   // Power event on pin 4.2 (pad 0), both driver types
   task automatic t_pme;
      drive(5'h1e, 5'h00);
      power_event <= 1'b1;
      wr(GPC_IDX_PIN_4_2, 32'h00);
      wr(GPC_IDX_DATA, 32'h01);
      look();
      chk("gpio out", 1'h1, pad_out[0]);
      wr(GPC_IDX_PIN_4_2, 32'h04);
      look();
      chk("event out", 1'h0, pad_out[0]);
      chk("event oe", 1'h1, pad_oe[0]);
      wr(GPC_IDX_PIN_4_2, 32'h84);
      look();
      chk("event od oe", 1'h1, pad_oe[0]);
      @(posedge aclk);
      power_event <= 1'b0;
      look();
      chk("idle od oe", 1'h0, pad_oe[0]);
      wr(GPC_IDX_PIN_4_2, 32'h04);
      look();
      chk("idle out", 1'h1, pad_out[0]);
      // Back to an input, so the board may drive pad 0 again without contention
      wr(GPC_IDX_PIN_4_2, 32'h01);
   endtask

   // Pin 4.3 (pad 1) as edge interrupt, then as select input with a wake mask
   task automatic t_edge;
      logic [31:0] q;
      drive(5'h1f, 5'h00);
      wr(GPC_IDX_MASK, 32'h01);
      wr(GPC_IDX_PIN_4_3, 32'h0d);
      look();
      rd(GPC_IDX_STATUS, q);
      drive(5'h1f, 5'h02);
      look();
      chk("edge irq", 1'h1, irq);
      rdc("rise status", GPC_IDX_STATUS, 32'h01);
      rdc("status cleared", GPC_IDX_STATUS, 32'h00);
      chk("irq cleared", 1'h0, irq);
      wr(GPC_IDX_MASK, 32'h00);
      drive(5'h1f, 5'h00);
      look();
      chk("masked irq", 1'h0, irq);
      rdc("fall status", GPC_IDX_STATUS, 32'h01);
      wr(GPC_IDX_MASK, 32'h02);
      wr(GPC_IDX_PIN_4_3, 32'h0b);
      look();
      chk("select inverted", 1'h1, floppy_parallel_select);
      rd(GPC_IDX_STATUS, q);
      drive(5'h1f, 5'h02);
      look();
      chk("select follows", 1'h0, floppy_parallel_select);
      chk("select irq", 1'h1, irq);
      rdc("select rise", GPC_IDX_STATUS, 32'h02);
      drive(5'h1f, 5'h00);
      look();
      rdc("select fall", GPC_IDX_STATUS, 32'h02);
   endtask

   // Request routing on pins 5.0 to 5.2 (pads 2 to 4), reserved codes give nothing
   task automatic t_isa;
      wr(GPC_IDX_PIN_5_0, 32'h09);
      wr(GPC_IDX_PIN_5_1, 32'h09);
      wr(GPC_IDX_PIN_5_2, 32'h09);
      drive(5'h1f, 5'h14);
      look();
      chk("isa route", 3'h5, isa_irq);
      wr(GPC_IDX_PIN_5_1, 32'h0b);
      look();
      chk("isa inverted", 3'h7, isa_irq);
      wr(GPC_IDX_PIN_5_0, 32'h05);
      wr(GPC_IDX_PIN_5_2, 32'h0d);
      look();
      chk("isa reserved", 3'h2, isa_irq);
   endtask

   // Guard mode locks itself; only the three resets may undo it
   task automatic t_lock;
      logic [31:0] q;
      drive(5'h1f, 5'h02);
      wr(GPC_IDX_PIN_4_3, 32'h06);
      look();
      chk("guard dir", 1'h0, pad_oe[1]);
      chk("guard high", 1'h1, disable_reg_guard);
      rd(GPC_IDX_DATA, q);
      chk("guard no invert", 1'h1, q[1]);
      drive(5'h1f, 5'h00);
      look();
      chk("guard low", 1'h0, disable_reg_guard);
      wr(GPC_IDX_PIN_4_3, 32'h8d);
      rdc("locked field", GPC_IDX_PIN_4_3, 32'h85);
      pulse(1'b0);
      rdc("main reset", GPC_IDX_PIN_4_3, 32'h81);
      wr(GPC_IDX_PIN_4_3, 32'h04);
      pulse(1'b1);
      rdc("hard reset", GPC_IDX_PIN_4_3, 32'h00);
      wr(GPC_IDX_PIN_4_3, 32'h04);
      do_reset();
      rdc("standby reset", GPC_IDX_PIN_4_3, 32'h01);
   endtask

   initial begin
      do_reset();
      t_reset();
      t_reserved();
      t_out();
      t_pme();
      t_edge();
      t_isa();
      t_lock();
      end_of_test();
   end
endmodule
